// ==== src/fb_prescaler_params.svh ====
// Constants for the feedback prescaler and status pin selector
// Overview of operation
// - With the counter bypass bit set, the main feedback counter divides by one.
// - Prescaler codes 000, 001 and 111 give fixed divide by 1, 2 and 3.
// - Code 010 divides by 2 or 3 with a nonzero swallow count, else by 2.
// - Code 011 divides by 4 or 5 with a nonzero swallow count, else by 4.
// - Code 100 divides by 8 or 9 with a nonzero swallow count, else by 8.
// - Code 101 divides by 16 or 17 with a nonzero swallow count, else by 16.
// - Code 110 is the reset default and divides by 32 or 33, else by 32.
// - Selector 000000 drives a static low; 000001 the delayed feedback output.
// - Codes 2 to 5 select reference, swallow, prescaler and up-pulse signals.
`ifndef FB_PRESCALER_PARAMS_SVH
`define FB_PRESCALER_PARAMS_SVH
`define ADDR_FB_CTRL 10'h016
`define ADDR_MON_SEL 10'h017
`define RST_FB_CTRL 8'h06
`define RST_MON_SEL 8'h00
`define BIT_CP_MID 7
`define BIT_RST_R 6
`define BIT_RST_AB 5
`define BIT_RST_ALL 4
`define BIT_BYPASS 3
`define PS_HI 2
`define PS_LO 0
`define SEL_HI 7
`define SEL_LO 2
`define SEL_GROUND 6'h00
`define SEL_N_OUT 6'h01
`define SEL_R_OUT 6'h02
`define SEL_A_OUT 6'h03
`define SEL_P_OUT 6'h04
`define SEL_PFD_UP 6'h05
`endif

// ==== src/fb_prescaler_pkg.sv ====
// Types shared by the feedback prescaler logic
package fb_prescaler_pkg;
   typedef enum logic [2:0] {
      PS_FD1 = 3'b000,
      PS_FD2 = 3'b001,
      PS_DM2 = 3'b010,
      PS_DM4 = 3'b011,
      PS_DM8 = 3'b100,
      PS_DM16 = 3'b101,
      PS_DM32 = 3'b110,
      PS_FD3 = 3'b111
   } prescaler_code_t;
endpackage

// ==== src/prescaler_core.sv ====
// Programmable modulus prescaler producing one pulse per prescaler cycle
`timescale 1ns/1ps
module prescaler_core #(
   parameter int MOD_W = 6
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic hold_i,
   input wire logic [MOD_W-1:0] modulus_i,
   output logic pulse_o
);
   logic [MOD_W-1:0] cnt_r;
   logic [MOD_W-1:0] cnt_nxt;
   logic last;

   // Last input cycle of the current prescaler cycle
   assign last = (cnt_r >= modulus_i - MOD_W'(1));
   assign pulse_o = last && !hold_i;

   // Count input cycles, wrap at the selected modulus
   always_comb begin
      if (hold_i || last) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + MOD_W'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// ==== src/feedback_prescaler_status_mux.sv ====
// Feedback divider control, prescaler decode and status pin selector
`timescale 1ns/1ps
`include "fb_prescaler_params.svh"
module feedback_prescaler_status_mux
   import fb_prescaler_pkg::*;
#(
   parameter int A_W = 6,
   parameter int B_W = 13
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [9:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [A_W-1:0] swallow_count_i,
   input wire logic [B_W-1:0] main_count_i,
   input wire logic ref_div_delayed_i,
   input wire logic pfd_up_i,
   output logic fb_div_o,
   output logic cp_mid_o,
   output logic r_counter_reset_o,
   output logic status_pin_o
);
   // Control registers, read data and their next values
   logic [7:0] fb_ctrl_r;
   logic [7:0] fb_ctrl_nxt;
   logic [7:0] mon_sel_r;
   logic [7:0] mon_sel_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   // Swallow and main counter state
   logic [A_W-1:0] a_rem_r;
   logic [A_W-1:0] a_rem_nxt;
   logic [B_W-1:0] b_rem_r;
   logic [B_W-1:0] b_rem_nxt;
   // Divider, swallow and pin output flops
   logic fb_div_r;
   logic fb_div_nxt;
   logic a_out_r;
   logic a_out_nxt;
   logic status_r;
   logic status_nxt;
   // Decoded settings and the prescaler pulse
   logic [5:0] modulus;
   logic p_pulse;
   logic hold_ab;
   logic period_end;
   logic [B_W-1:0] b_load;
   prescaler_code_t p_code;
   logic [5:0] sel;
   // Write strobes for each control register
   logic wr_fb;
   logic wr_mon;

   // Modulus for one prescaler cycle; swallow selects the larger one
   // Fixed divide codes ignore the swallow count, so a stray nonzero
   // count cannot stretch their cycles
   function automatic logic [5:0] pick_modulus(input prescaler_code_t c,
                                              input logic swallow);
      logic [5:0] base;
      logic dual;
      base = 6'h01;
      dual = 1'b1;
      unique case (c)
         PS_FD1: begin
            base = 6'h01;
            dual = 1'b0;
         end
         PS_FD2: begin
            base = 6'h02;
            dual = 1'b0;
         end
         PS_FD3: begin
            base = 6'h03;
            dual = 1'b0;
         end
         PS_DM2: base = 6'h02;
         PS_DM4: base = 6'h04;
         PS_DM8: base = 6'h08;
         PS_DM16: base = 6'h10;
         PS_DM32: base = 6'h20;
      endcase
      // Dual modulus adds one while swallow cycles remain
      return base + {5'h00, dual && swallow};
   endfunction

   // Fields of the control bytes
   assign p_code = prescaler_code_t'(fb_ctrl_r[`PS_HI:`PS_LO]);
   assign sel = mon_sel_r[`SEL_HI:`SEL_LO];
   // The AB or the all reset bit holds the prescaler and both counters at their loads
   assign hold_ab = fb_ctrl_r[`BIT_RST_AB] || fb_ctrl_r[`BIT_RST_ALL];
   // Modulus follows the swallow count, which moves only on a pulse or while held
   assign modulus = pick_modulus(p_code, a_rem_r != '0);
   // Bypass forces one prescaler cycle per feedback period
   // A main count of zero is taken as one so a period never stalls
   assign b_load = (fb_ctrl_r[`BIT_BYPASS] || main_count_i == '0) ?
                   B_W'(1) : main_count_i;
   // Last prescaler cycle of the feedback period
   assign period_end = p_pulse && (b_rem_r <= B_W'(1));
   // Write strobes decoded once for the register process
   assign wr_fb = reg_wr_i && reg_addr_i == `ADDR_FB_CTRL;
   assign wr_mon = reg_wr_i && reg_addr_i == `ADDR_MON_SEL;

   // Prescaler core; a mode change mid-cycle wraps it at once when its
   // count already lies past the new modulus
   prescaler_core #(
      .MOD_W(6)
   ) u_prescaler (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .hold_i(hold_ab),
      .modulus_i(modulus),
      .pulse_o(p_pulse)
   );

   // Register writes and registered read data
   always_comb begin
      // Writes land at the next edge; unmapped addresses are ignored
      fb_ctrl_nxt = fb_ctrl_r;
      mon_sel_nxt = mon_sel_r;
      if (wr_fb) begin
         fb_ctrl_nxt = reg_wdata_i;
      end
      if (wr_mon) begin
         mon_sel_nxt = reg_wdata_i;
      end
      // Read data follows the address; unmapped addresses read zero
      unique case (reg_addr_i)
         `ADDR_FB_CTRL: rdata_nxt = fb_ctrl_r;
         `ADDR_MON_SEL: rdata_nxt = mon_sel_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Register the control bytes and the read data
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         fb_ctrl_r <= `RST_FB_CTRL;
         mon_sel_r <= `RST_MON_SEL;
         rdata_r <= 8'h00;
      end else begin
         fb_ctrl_r <= fb_ctrl_nxt;
         mon_sel_r <= mon_sel_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Swallow and main counters; each period is B prescaler cycles
   always_comb begin
      a_rem_nxt = a_rem_r;
      b_rem_nxt = b_rem_r;
      fb_div_nxt = fb_div_r;
      a_out_nxt = a_out_r;
      // Held counters wait at their loads with both outputs low
      if (hold_ab) begin
         a_rem_nxt = swallow_count_i;
         b_rem_nxt = b_load;
         fb_div_nxt = 1'b0;
         a_out_nxt = 1'b0;
      end else if (p_pulse) begin
         // New counts are taken here, at the start of a period, and in the hold branch above
         if (period_end) begin
            a_rem_nxt = swallow_count_i;
            b_rem_nxt = b_load;
            fb_div_nxt = !fb_div_r;
         end else begin
            b_rem_nxt = b_rem_r - B_W'(1);
            // Swallow cycles run first until the count is spent
            if (a_rem_r != '0) begin
               a_rem_nxt = a_rem_r - A_W'(1);
               // Swallow output toggles as the count reaches zero
               if (a_rem_r == A_W'(1)) begin
                  a_out_nxt = !a_out_r;
               end
            end
         end
      end
   end

   // Register the counters; reset starts a period of one prescaler cycle
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         a_rem_r <= '0;
         b_rem_r <= B_W'(1);
         fb_div_r <= 1'b0;
         a_out_r <= 1'b0;
      end else begin
         a_rem_r <= a_rem_nxt;
         b_rem_r <= b_rem_nxt;
         fb_div_r <= fb_div_nxt;
         a_out_r <= a_out_nxt;
      end
   end

   // Status pin source selection, registered before the pin
   always_comb begin
      // Codes outside the decoded set show ground
      unique case (sel)
         `SEL_GROUND: status_nxt = 1'b0;
         `SEL_N_OUT: status_nxt = fb_div_r;
         `SEL_R_OUT: status_nxt = ref_div_delayed_i;
         `SEL_A_OUT: status_nxt = a_out_r;
         `SEL_P_OUT: status_nxt = p_pulse;
         `SEL_PFD_UP: status_nxt = pfd_up_i;
         default: status_nxt = 1'b0;
      endcase
   end

   // Register the pin so it never glitches between sources
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         status_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
      end
   end

   // Outputs straight from flops
   assign reg_rdata_o = rdata_r;
   assign fb_div_o = fb_div_r;
   // Charge pump and reference divider controls from the stored bits
   assign cp_mid_o = fb_ctrl_r[`BIT_CP_MID];
   assign r_counter_reset_o = fb_ctrl_r[`BIT_RST_R] || fb_ctrl_r[`BIT_RST_ALL];
   assign status_pin_o = status_r;
endmodule

// ==== tb/fps_mux_checker.sv ====
// Port assertions for the prescaler and status selector
`timescale 1ns/1ps
module fps_mux_checker #(
   parameter int A_W = 6,
   parameter int B_W = 13
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [9:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [A_W-1:0] swallow_count_i,
   input wire logic [B_W-1:0] main_count_i,
   input wire logic ref_div_delayed_i,
   input wire logic pfd_up_i,
   input wire logic fb_div_o,
   input wire logic cp_mid_o,
   input wire logic r_counter_reset_o,
   input wire logic status_pin_o
);
   logic [7:0] fb_r, sel_r, age_r, rd_exp;
   logic settled;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   // Shadow registers and cycles since the last write
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         fb_r <= 8'h06;
         sel_r <= 8'h00;
      end else if (reg_wr_i && reg_addr_i == 10'h016) fb_r <= reg_wdata_i;
      else if (reg_wr_i && reg_addr_i == 10'h017) sel_r <= reg_wdata_i;
      if (srst_i || reg_wr_i) age_r <= 8'h00;
      else if (age_r != 8'hff) age_r <= age_r + 8'h01;
   end
   // Old periods have drained once the setting is this old
   assign settled = age_r > 8'h78 && swallow_count_i == '0;
   assign rd_exp = (reg_addr_i == 10'h016) ? fb_r :
                   (reg_addr_i == 10'h017) ? sel_r : 8'h00;
   ground_low_a: assert property (
      (sel_r[7:2] == 6'h00 || sel_r[7:2] > 6'h05) |=> !status_pin_o)
      else $error("status pin not low");
   fb_pass_a: assert property (
      sel_r[7:2] == 6'h01 |=> status_pin_o == $past(fb_div_o))
      else $error("feedback output not on status pin");
   ref_pass_a: assert property (
      sel_r[7:2] == 6'h02 |=> status_pin_o == $past(ref_div_delayed_i))
      else $error("reference output not on status pin");
   up_pass_a: assert property (
      sel_r[7:2] == 6'h05 |=> status_pin_o == $past(pfd_up_i))
      else $error("up pulse not on status pin");
   div_one_a: assert property (
      (settled && fb_r[5:0] == 6'h08) |-> fb_div_o != $past(fb_div_o))
      else $error("divide by one wrong");
   div_two_a: assert property (
      (settled && (fb_r[5:0] == 6'h09 || fb_r[5:0] == 6'h0a))
      |-> fb_div_o != $past(fb_div_o, 2))
      else $error("divide by two wrong");
   div_three_a: assert property (
      (settled && fb_r[5:0] == 6'h0f) |-> fb_div_o != $past(fb_div_o, 3))
      else $error("divide by three wrong");
   read_back_a: assert property (
      !reg_wr_i |=> reg_rdata_o == $past(rd_exp))
      else $error("read data wrong");
endmodule
bind feedback_prescaler_status_mux fps_mux_checker
   #(.A_W(A_W), .B_W(B_W)) chk (.*);

// ==== tb/feedback_prescaler_status_mux_test.sv ====
// Self-checking bench for the prescaler and status selector
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %0t got %h exp %h", $time, g, e); end end
module feedback_prescaler_status_mux_test;
   logic core_clk_i = 0, srst_i = 1, wr_i = 0, ref_i = 0, up_i = 0, e;
   logic [9:0] addr = 0;
   logic [7:0] wdata = 0, rdata;
   logic [5:0] a_cnt = 0; // Zero while bypass is set
   logic [12:0] b_cnt = 0;
   logic fb, stat, cpm, rcr;
   logic [7:0] hc[3] = '{8'h28, 8'h18, 8'hc8};
   logic hp[3] = '{1'b0, 1'b0, 1'b1};
   logic [1:0] hr[3] = '{2'b00, 2'b01, 2'b11};
   int mismatches = 0, checked = 0, n;
   int ps[8] = '{1, 2, 2, 4, 8, 16, 32, 3};
   logic [5:0] sc[4] = '{6'h00, 6'h02, 6'h05, 6'h06};
   always #12.5 core_clk_i = ~core_clk_i;
   feedback_prescaler_status_mux dut (.core_clk_i(core_clk_i),
      .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr_i), .reg_rdata_o(rdata), .swallow_count_i(a_cnt),
      .main_count_i(b_cnt), .ref_div_delayed_i(ref_i), .pfd_up_i(up_i),
      .fb_div_o(fb), .cp_mid_o(cpm), .r_counter_reset_o(rcr),
      .status_pin_o(stat));
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] x);
      addr <= a;
      repeat (2) @(posedge core_clk_i);
      #1 `CHK(rdata, x)
      @(posedge core_clk_i);
   endtask
   // Cycles until the feedback output, or the status pin, next changes
   task automatic tog(input bit s);
      logic v;
      v = s ? stat : fb;
      n = 0;
      do begin
         @(posedge core_clk_i);
         #1 n++;
      end while ((s ? stat : fb) === v && n < 300);
   endtask
   task automatic per(input int x, input bit s);
      repeat (130) @(posedge core_clk_i);
      #1 tog(s);
      tog(s);
      `CHK(n, x)
      @(posedge core_clk_i);
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #400000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge core_clk_i);
      srst_i <= 1'b0;
      rd(10'h016, 8'h06);
      rd(10'h017, 8'h00);
      wr(10'h018, 8'hff);
      rd(10'h018, 8'h00);
      for (int c = 0; c < 8; c++) begin
         wr(10'h016, 8'h08 | c[7:0]);
         per(ps[c], 1'b0);
      end
      b_cnt <= 13'h3;
      a_cnt <= 6'h2;
      for (int c = 2; c < 7; c++) begin
         wr(10'h016, c[7:0]);
         per(3 * ps[c] + 2, 1'b0);
      end
      a_cnt <= 6'h0;
      per(3 * ps[6], 1'b0);
      foreach (sc[i]) begin
         wr(10'h017, {sc[i], 2'b00});
         for (int v = 0; v < 2; v++) begin
            ref_i <= v[0];
            up_i <= ~v[0];
            e = (sc[i] == 6'h02) ? v[0] : (sc[i] == 6'h05) ? ~v[0] : 1'b0;
            repeat (2) @(posedge core_clk_i);
            #1 `CHK(stat, e)
            @(posedge core_clk_i);
         end
      end
      // Swallow output on the pin, then prescaler pulse and cp/reset outputs under each reset bit
      a_cnt <= 6'h2;
      wr(10'h016, 8'h02);
      wr(10'h017, 8'h0c);
      per(8, 1'b1);
      a_cnt <= 6'h0;
      foreach (hc[i]) begin
         wr(10'h016, hc[i]);
         wr(10'h017, 8'h10);
         repeat (2) @(posedge core_clk_i);
         #1 `CHK(stat, hp[i])
         `CHK({cpm, rcr}, hr[i])
         @(posedge core_clk_i);
      end
      wr(10'h017, 8'h04);
      repeat (100) @(posedge core_clk_i);
      report_and_stop();
   end
endmodule
